// File: flash_prot_regs.sv
// protection, option and reserved registers of the flash controller
// assumes a same-clock avalon-mm master, config loader and command checker
`timescale 1ns/100ps

// Summary of operation
// [RL1] illegal pflash scenario write is silently dropped
// [RL2] fixed table of allowed scenario moves
// [RL3] pflash register reads the scenario in force
// [RL4] eeprom size field only grows
// [RL5] eeprom open bit only goes 1 to 0
// [RL6] open bit set means eeprom unprotected
// [RL7] open bit clear protects size-selected range
// [RL8] range from 0x10_0000, (size+1)*32 bytes
// [RL9] eeprom byte loaded from config at reset
// [RL10] eeprom load fault means full protection
// [RL11] protected target refused, violation flag set
// [RL12] eeprom block erase refused if any protected
// [RL13] option register read only
// [RL14] option register loaded from config at reset
// [RL15] option load fault sets all ones
// [RL16] reserved register reads zero, ignores writes
// [RL17] size fields writable only while disabled
// [RL18] open clear, both disabled: all pflash protected
// [RL19] control bits map to scenarios by table
// [RL20] judge write against old value, apply now
module flash_prot_regs
    import flash_prot_pkg::*;
#(
    parameter logic [23:0] SCEN_MAP = SCEN_MAP_DEF
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic cfg_load,
    input wire logic [7:0] cfg_pprot_byte,
    input wire logic [7:0] cfg_eprot_byte,
    input wire logic [7:0] cfg_opt_byte,
    input wire logic cfg_pprot_dbl,
    input wire logic cfg_eprot_dbl,
    input wire logic cfg_opt_dbl,
    input wire logic chk_req,
    input wire logic [23:0] chk_addr,
    input wire logic chk_eeprom,
    input wire logic chk_blk_erase,
    output logic chk_ack,
    output logic chk_refused,
    output logic protect_violation_flag
);

    logic [7:0] pflash_protect_reg_ff;
    logic [7:0] eeprom_protect_reg_ff;
    logic [7:0] option_byte_reg_ff;
    logic viol_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic ack_ff;
    logic refused_ff;
    logic [7:0] nxt_pprot;
    logic [7:0] nxt_eprot;
    logic nxt_viol;

    // scenario of a protection byte
    function automatic logic [2:0] scen_of(input logic [7:0] v);
        logic [2:0] idx;
        idx = {v[PP_OPEN], v[PP_HDIS], v[PP_LDIS]};
        scen_of = SCEN_MAP[idx*3 +: 3]; // [RL19]
    endfunction

    // bus decode
    wire logic [3:0] idx = address[5:2];
    wire logic req = read | write;
    wire logic commit_wr = write & ~wait_ff & byteenable[0];
    wire logic [7:0] wbyte = writedata[7:0];
    wire logic wr_pprot = commit_wr & (idx == IDX_PPROT);
    wire logic wr_eprot = commit_wr & (idx == IDX_EPROT);
    wire logic wr_stat = commit_wr & (idx == IDX_STAT);
    wire logic [7:0] stat_byte = {7'h00, viol_ff};
    wire logic [7:0] rd_byte =
        (idx == IDX_PPROT) ? pflash_protect_reg_ff : // [RL3]
        (idx == IDX_EPROT) ? eeprom_protect_reg_ff :
        (idx == IDX_OPT) ? option_byte_reg_ff : // [RL13]
        (idx == IDX_STAT) ? stat_byte :
        8'h00; // [RL16]

    // pflash write: size fields held unless their disable bit is set now
    wire logic hs_ok = pflash_protect_reg_ff[PP_HDIS]; // [RL17]
    wire logic ls_ok = pflash_protect_reg_ff[PP_LDIS]; // [RL17]
    wire logic [1:0] cand_hs = hs_ok ? wbyte[PP_HS_LSB +: 2]
                                     : pflash_protect_reg_ff[PP_HS_LSB +: 2];
    wire logic [1:0] cand_ls = ls_ok ? wbyte[PP_LS_LSB +: 2]
                                     : pflash_protect_reg_ff[PP_LS_LSB +: 2];
    wire logic [7:0] cand_pprot = {wbyte[PP_OPEN], pflash_protect_reg_ff[PP_RNV],
                                   wbyte[PP_HDIS], cand_hs, wbyte[PP_LDIS], cand_ls};
    wire logic [2:0] scen_old = scen_of(pflash_protect_reg_ff); // [RL20]
    wire logic [2:0] scen_new = scen_of(cand_pprot);
    wire logic move_ok = SCEN_ALLOWED[{scen_old, scen_new}]; // [RL2]

    // eeprom write: open only clears, size only grows
    wire logic [5:0] dps_old = eeprom_protect_reg_ff[EP_DPS_LSB +: EP_DPS_W];
    wire logic [5:0] dps_wr = wbyte[EP_DPS_LSB +: EP_DPS_W];
    wire logic open_new = eeprom_protect_reg_ff[EP_OPEN] & wbyte[EP_OPEN]; // [RL5]
    wire logic [5:0] dps_new = (dps_wr > dps_old) ? dps_wr : dps_old; // [RL4]

    // eeprom protection check
    wire logic ee_open = eeprom_protect_reg_ff[EP_OPEN];
    wire logic [23:0] ee_off = chk_addr - EE_BASE;
    wire logic ee_in_range = (chk_addr >= EE_BASE)
                           & (ee_off[23:EE_STEP_LSB] <= {13'h0000, dps_old}); // [RL8]
    wire logic ee_prot = ~ee_open & ee_in_range; // [RL6] [RL7]
    wire logic ee_any = ~ee_open; // [RL12]

    // pflash protection check
    wire logic pf_open = pflash_protect_reg_ff[PP_OPEN];
    wire logic pf_hdis = pflash_protect_reg_ff[PP_HDIS];
    wire logic pf_ldis = pflash_protect_reg_ff[PP_LDIS];
    wire logic [1:0] pf_hs = pflash_protect_reg_ff[PP_HS_LSB +: 2];
    wire logic [1:0] pf_ls = pflash_protect_reg_ff[PP_LS_LSB +: 2];
    wire logic [15:0] hi_size = PF_HI_MIN << pf_hs;
    wire logic [14:0] lo_size = PF_LO_MIN << pf_ls;
    wire logic [15:0] hi_dist = ~chk_addr[15:0];
    wire logic in_hi = (chk_addr[23:16] == PF_HI_PAGE) & (hi_dist < hi_size);
    wire logic in_lo = (chk_addr[23:15] == PF_LO_PAGE) & (chk_addr[14:0] < lo_size);
    wire logic in_sel = (~pf_hdis & in_hi) | (~pf_ldis & in_lo);
    wire logic pf_prot = pf_open ? in_sel : ~in_sel; // [RL18]
    wire logic pf_any = ~(pf_open & pf_hdis & pf_ldis);

    wire logic target_prot = chk_eeprom ? ee_prot : pf_prot;
    wire logic blk_prot = chk_eeprom ? ee_any : pf_any; // [RL12]
    wire logic refuse = chk_req & (chk_blk_erase ? blk_prot : target_prot); // [RL11]

    // next values of the protection registers
    always_comb
    begin
        nxt_pprot = pflash_protect_reg_ff;
        nxt_eprot = eeprom_protect_reg_ff;
        if (cfg_load)
        begin
            nxt_pprot = cfg_pprot_dbl ? PPROT_FAULT : cfg_pprot_byte;
            nxt_eprot = cfg_eprot_dbl ? EPROT_FAULT : (cfg_eprot_byte & EPROT_WMASK); // [RL9] [RL10]
        end
        else
        begin
            if (wr_pprot && move_ok)
            begin
                nxt_pprot = cand_pprot; // [RL1] [RL20]
            end
            if (wr_eprot)
            begin
                nxt_eprot = {open_new, 1'b0, dps_new}; // [RL4] [RL5]
            end
        end
    end

    // violation flag: set beats write-one-to-clear
    always_comb
    begin
        nxt_viol = viol_ff;
        if (wr_stat && wbyte[ST_VIOL])
        begin
            nxt_viol = 1'b0;
        end
        if (refuse)
        begin
            nxt_viol = 1'b1; // [RL11]
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pflash_protect_reg_ff <= PPROT_RST;
            eeprom_protect_reg_ff <= EPROT_RST;
            option_byte_reg_ff <= OPT_RST;
        end
        else
        begin
            pflash_protect_reg_ff <= nxt_pprot;
            eeprom_protect_reg_ff <= nxt_eprot;
            if (cfg_load)
            begin
                option_byte_reg_ff <= cfg_opt_dbl ? OPT_FAULT : cfg_opt_byte; // [RL14] [RL15]
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            viol_ff <= 1'b0;
            ack_ff <= 1'b0;
            refused_ff <= 1'b0;
        end
        else
        begin
            viol_ff <= nxt_viol;
            ack_ff <= chk_req;
            refused_ff <= refuse; // [RL11]
        end
    end

    // one wait cycle per bus access, read data captured with it
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h00000000;
        end
        else
        begin
            wait_ff <= ~(req & wait_ff);
            if (read && wait_ff)
            begin
                rdata_ff <= {24'h000000, rd_byte};
            end
        end
    end

    assign readdata = rdata_ff;
    assign waitrequest = wait_ff;
    assign chk_ack = ack_ff;
    assign chk_refused = refused_ff;
    assign protect_violation_flag = viol_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence seq_refused_req;
        chk_req && !cfg_load ##0 refuse;
    endsequence

    sequence seq_flag_shows;
        chk_refused && protect_violation_flag;
    endsequence

    a_pprot_bad_drop: assert property (wr_pprot && !cfg_load && !move_ok
        |=> $stable(pflash_protect_reg_ff)) // [RL1]
        else $error("illegal scenario write changed pflash register");
    a_pprot_move_legal: assert property (!$past(cfg_load) && $changed(pflash_protect_reg_ff)
        |-> SCEN_ALLOWED[{scen_of($past(pflash_protect_reg_ff)), scen_of(pflash_protect_reg_ff)}]) // [RL2]
        else $error("pflash scenario moved along a forbidden path");
    a_pprot_read_back: assert property (read && wait_ff && idx == IDX_PPROT
        |=> readdata[7:0] == $past(pflash_protect_reg_ff) && !waitrequest) // [RL3]
        else $error("pflash read did not return the scenario in force");
    a_eprot_size_grow: assert property (!$past(cfg_load)
        |-> eeprom_protect_reg_ff[5:0] >= $past(eeprom_protect_reg_ff[5:0])) // [RL4]
        else $error("eeprom protection size shrank");
    a_eprot_open_once: assert property (!$past(cfg_load) && !$past(eeprom_protect_reg_ff[EP_OPEN])
        |-> !eeprom_protect_reg_ff[EP_OPEN]) // [RL5]
        else $error("eeprom open bit went back to one");
    a_eprot_fault_full: assert property (cfg_load && cfg_eprot_dbl
        |=> eeprom_protect_reg_ff == EPROT_FAULT) // [RL10]
        else $error("eeprom load fault left eeprom unprotected");
    a_viol_flag_set: assert property (seq_refused_req |=> seq_flag_shows) // [RL11]
        else $error("refused command did not raise the violation flag");
    a_eeprom_open_pass: assert property (chk_req && chk_eeprom && !chk_blk_erase && ee_open
        |=> chk_ack && !chk_refused) // [RL6]
        else $error("open eeprom refused a command");
    a_ee_blk_erase: assert property (chk_req && chk_eeprom && chk_blk_erase && !ee_open
        |=> chk_refused) // [RL12]
        else $error("eeprom block erase allowed while protected");
    a_opt_read_only: assert property (!$past(cfg_load) |-> $stable(option_byte_reg_ff)) // [RL13]
        else $error("option register changed without a config load");
    a_opt_fault_ones: assert property (cfg_load && cfg_opt_dbl
        |=> option_byte_reg_ff == OPT_FAULT) // [RL15]
        else $error("option load fault did not set all ones");
    a_rsv_reads_zero: assert property (read && wait_ff && idx == IDX_RSV
        |=> readdata == 32'h00000000) // [RL16]
        else $error("reserved register read nonzero");
    a_bus_one_wait: assert property (req && wait_ff |=> !waitrequest ##1 waitrequest)
        else $error("bus access not answered after one wait cycle");

    // program and erase checks by region
    sequence seq_ee_write_check;
        chk_req && chk_eeprom && !chk_blk_erase && !cfg_load;
    endsequence

    sequence seq_pf_write_check;
        chk_req && !chk_eeprom && !chk_blk_erase && !cfg_load;
    endsequence

    a_eprot_load_byte: assert property (cfg_load && !cfg_eprot_dbl // [RL9]
        |=> eeprom_protect_reg_ff == ($past(cfg_eprot_byte) & EPROT_WMASK))
        else $error("eeprom register not loaded from config byte");

    a_opt_load_byte: assert property (cfg_load && !cfg_opt_dbl // [RL14]
        |=> option_byte_reg_ff == $past(cfg_opt_byte))
        else $error("option register not loaded from config byte");

    a_opt_read_data: assert property (read && wait_ff && idx == IDX_OPT // [RL13]
        |=> readdata[7:0] == $past(option_byte_reg_ff))
        else $error("option read did not return the register");

    a_ee_range_refuse: assert property (seq_ee_write_check ##0 ee_prot // [RL7]
        |=> chk_refused)
        else $error("protected eeprom target not refused");

    a_ee_outside_pass: assert property (seq_ee_write_check ##0 !ee_in_range // [RL8]
        |=> !chk_refused)
        else $error("eeprom target outside range refused");

    a_pf_full_refuse: assert property (seq_pf_write_check // [RL18]
        ##0 (!pf_open && pf_hdis && pf_ldis) |=> chk_refused)
        else $error("fully protected pflash target not refused");

    a_pf_blk_erase: assert property (chk_req && !chk_eeprom && chk_blk_erase && pf_any // [RL12]
        |=> chk_refused)
        else $error("pflash block erase allowed while protected");

    a_hsize_locked: assert property (wr_pprot && !cfg_load && !hs_ok // [RL17]
        |=> pflash_protect_reg_ff[4:3] == $past(pflash_protect_reg_ff[4:3]))
        else $error("high size changed while its range was enabled");

    a_lsize_locked: assert property (wr_pprot && !cfg_load && !ls_ok // [RL17]
        |=> pflash_protect_reg_ff[1:0] == $past(pflash_protect_reg_ff[1:0]))
        else $error("low size changed while its range was enabled");

    a_pprot_good_take: assert property (wr_pprot && !cfg_load && move_ok // [RL20]
        |=> pflash_protect_reg_ff == $past(cand_pprot))
        else $error("legal pflash write not applied");

    a_viol_clear_w1c: assert property (wr_stat && wbyte[ST_VIOL] && !refuse // [RL11]
        |=> !protect_violation_flag)
        else $error("violation flag not cleared by write one");

    a_chk_ack_next: assert property (chk_req |=> chk_ack)
        else $error("check request not acknowledged next cycle");

    a_chk_ack_idle: assert property (!chk_req |=> !chk_ack && !chk_refused)
        else $error("check answer without a request");
endmodule

// File: flash_prot_pkg.sv
// constants for the flash protection and option register block
// assumes a 32-bit avalon-mm slave with byte addresses, data in the low byte
package flash_prot_pkg;
    // register indices, byte address is four times the index
    localparam logic [3:0] IDX_PPROT = 4'h8;
    localparam logic [3:0] IDX_EPROT = 4'h9;
    localparam logic [3:0] IDX_OPT = 4'hA;
    localparam logic [3:0] IDX_RSV = 4'hB;
    localparam logic [3:0] IDX_STAT = 4'hC;
    // pflash protection field positions
    localparam int PP_OPEN = 7;
    localparam int PP_RNV = 6;
    localparam int PP_HDIS = 5;
    localparam int PP_HS_LSB = 3;
    localparam int PP_LDIS = 2;
    localparam int PP_LS_LSB = 0;
    // eeprom protection field positions
    localparam int EP_OPEN = 7;
    localparam int EP_DPS_LSB = 0;
    localparam int EP_DPS_W = 6;
    // status register field
    localparam int ST_VIOL = 0;
    // values after reset and after a double-bit fault on load
    localparam logic [7:0] PPROT_RST = 8'h7F;
    localparam logic [7:0] EPROT_RST = 8'h3F;
    localparam logic [7:0] OPT_RST = 8'hFF;
    localparam logic [7:0] PPROT_FAULT = 8'h7F;
    localparam logic [7:0] EPROT_FAULT = 8'h3F;
    localparam logic [7:0] OPT_FAULT = 8'hFF;
    localparam logic [7:0] EPROT_WMASK = 8'hBF;
    // address map of the protected areas
    localparam logic [23:0] EE_BASE = 24'h100000;
    localparam int EE_STEP_LSB = 5;
    localparam logic [7:0] PF_HI_PAGE = 8'hFF;
    localparam logic [15:0] PF_HI_MIN = 16'h0800;
    localparam logic [8:0] PF_LO_PAGE = 9'h1FF;
    localparam logic [14:0] PF_LO_MIN = 15'h0400;
    // allowed scenario moves, bit from*8+to
    localparam logic [63:0] SCEN_ALLOWED = 64'hFF5A3C18080C0A0F;
    // control bits {open,hdis,ldis} to scenario, 3 bits per entry
    localparam logic [23:0] SCEN_MAP_DEF = 24'hFAC688;
endpackage

// File: flash_prot_regs_tb_top.sv
// testbench for the flash protection and option register block
// assumes flash_prot_regs and its package compiled first, one 250 MHz clock
`timescale 1ns/100ps
module flash_prot_regs_tb_top;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic [5:0] address = 6'h00;
    logic read = 1'h0;
    logic write = 1'h0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic cfg_load = 1'h0;
    logic [7:0] p_byte = 8'h00;
    logic [7:0] e_byte = 8'h00;
    logic [7:0] o_byte = 8'h00;
    logic dbl = 1'h0;
    logic chk_req = 1'h0;
    logic [23:0] chk_addr = 24'h0;
    logic chk_eeprom = 1'h0;
    logic chk_blk_erase = 1'h0;
    logic chk_ack;
    logic chk_refused;
    logic protect_violation_flag;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;

    flash_prot_regs flash_prot_regs_i (.clock(clock), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .byteenable(4'hF), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .cfg_load(cfg_load),
        .cfg_pprot_byte(p_byte), .cfg_eprot_byte(e_byte), .cfg_opt_byte(o_byte),
        .cfg_pprot_dbl(dbl), .cfg_eprot_dbl(dbl), .cfg_opt_dbl(dbl), .chk_req(chk_req),
        .chk_addr(chk_addr), .chk_eeprom(chk_eeprom), .chk_blk_erase(chk_blk_erase),
        .chk_ack(chk_ack), .chk_refused(chk_refused),
        .protect_violation_flag(protect_violation_flag));

    always #2 clock = ~clock;

    task automatic report_and_stop;
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // bounded run length
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            $display("mismatch at %0t: timeout", $time);
            report_and_stop;
        end
    end

    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
        output logic [31:0] q);
        address <= a;
        writedata <= {24'h000000, d};
        read <= ~wr;
        write <= wr;
        @(posedge clock);
        while (waitrequest !== 1'h0)
        begin
            @(posedge clock);
        end
        q = readdata;
        read <= 1'h0;
        write <= 1'h0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'h0, a, 8'h00, q);
        cmp_data(q, {24'h000000, e});
    endtask

    task automatic load(input logic [7:0] p, input logic [7:0] e, input logic [7:0] o,
        input logic f);
        p_byte <= p;
        e_byte <= e;
        o_byte <= o;
        dbl <= f;
        cfg_load <= 1'h1;
        @(posedge clock);
        cfg_load <= 1'h0;
        @(posedge clock);
    endtask

    // program/erase check, answer one cycle after the request
    task automatic chk(input logic [23:0] a, input logic ee, input logic blk, input logic r);
        chk_addr <= a;
        chk_eeprom <= ee;
        chk_blk_erase <= blk;
        chk_req <= 1'h1;
        @(posedge clock);
        chk_req <= 1'h0;
        @(negedge clock);
        cmp_bit(chk_ack, 1'h1);
        cmp_bit(chk_refused, r);
        if (r)
            cmp_bit(protect_violation_flag, 1'h1);
        @(posedge clock);
    endtask

    function automatic logic [7:0] scen_byte(input int s);
        return {s[2], 1'h0, s[1], 2'h0, s[0], 2'h0};
    endfunction

    task automatic t_reset_and_fault;
        rd(6'h20, 8'h7F);
        rd(6'h24, 8'h3F);
        rd(6'h28, 8'hFF);
        rd(6'h2C, 8'h00);
        rd(6'h3C, 8'h00);
        load(8'h00, 8'h00, 8'h00, 1'h1);
        rd(6'h24, 8'h3F);
        rd(6'h28, 8'hFF);
    endtask

    task automatic t_option;
        load(8'hA4, 8'h85, 8'hA5, 1'h0);
        rd(6'h24, 8'h85);
        rd(6'h28, 8'hA5);
        wr(6'h28, 8'h00);
        rd(6'h28, 8'hA5);
        wr(6'h2C, 8'hFF);
        rd(6'h2C, 8'h00);
        chk(24'h100000, 1'h1, 1'h0, 1'h0);
        cmp_bit(protect_violation_flag, 1'h0);
    endtask

    task automatic t_eeprom;
        wr(6'h24, 8'h83);
        rd(6'h24, 8'h85);
        wr(6'h24, 8'h07);
        rd(6'h24, 8'h07);
        wr(6'h24, 8'h86);
        rd(6'h24, 8'h07);
        chk(24'h1000FF, 1'h1, 1'h0, 1'h1);
        chk(24'h100100, 1'h1, 1'h0, 1'h0);
        wr(6'h30, 8'h01);
        rd(6'h30, 8'h00);
        chk(24'h100100, 1'h1, 1'h1, 1'h1);
    endtask

    task automatic t_scenarios;
        logic [7:0] ok [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
        for (int f = 0; f < 8; f++)
            for (int t = 0; t < 8; t++)
            begin
                load(scen_byte(f), 8'h80, 8'hFF, 1'h0);
                wr(6'h20, scen_byte(t));
                rd(6'h20, ok[f][t] ? scen_byte(t) : scen_byte(f));
            end
    endtask

    task automatic t_pflash;
        load(8'h80, 8'h80, 8'hFF, 1'h0);
        wr(6'h20, 8'h98);
        rd(6'h20, 8'h80);
        load(8'hA4, 8'h80, 8'hFF, 1'h0);
        wr(6'h20, 8'hBF);
        rd(6'h20, 8'hBF);
        chk(24'hFF8000, 1'h0, 1'h0, 1'h0);
        load(8'h24, 8'h80, 8'hFF, 1'h0);
        chk(24'hFF8000, 1'h0, 1'h0, 1'h1);
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        t_reset_and_fault;
        t_option;
        t_eeprom;
        t_scenarios;
        t_pflash;
        report_and_stop;
    end
endmodule
